// *** tcf_pkg.sv ***
// Purpose: shared constants of the auto-reload timer control block
// Assumes: 8-bit register port, one system clock
// Notes: offsets are byte addresses on the register port
package tcf_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hD0;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hD1;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'hD2;
  localparam logic [3:0] SFR_PAGE = 4'h0;
  localparam logic [4:0] CONTROL_BIT_BASE = 5'h19;
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_XCLK_HI = 1;
  localparam int BIT_XCLK_LO = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] XCLK_DIV12_RTC = 2'h0;
  localparam logic [1:0] XCLK_COMP_RTC = 2'h1;
  localparam logic [1:0] XCLK_DIV12_COMP = 2'h2;
  localparam logic [1:0] XCLK_RTC_COMP = 2'h3;
  localparam int IRQ_HIGH = 0;
  localparam int IRQ_LOW = 1;
  localparam int IRQ_WIDTH = 2;
  localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 2'h0;
  localparam int PRESCALE_DIV = 12;
  localparam int RTC_DIV = 8;
endpackage : tcf_pkg

// *** tcf_tick_gen.sv ***
// Purpose: one-cycle ticks for prescaled clock, rtc/8 and comparator edges
// Assumes: rtc and comparator inputs already synchronous to clock
// Notes: ticks come from flops, one cycle after the edge
`timescale 1ns/1ns
module tcf_tick_gen #(
  parameter int PRESCALE = tcf_pkg::PRESCALE_DIV,
  parameter int RTC_EDGES = tcf_pkg::RTC_DIV
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic rtc_in,
  input wire logic comparator_in,
  output logic div12_tick,
  output logic rtc8_tick,
  output logic comp_tick
);
  localparam int PW = $clog2(PRESCALE);
  localparam int RW = $clog2(RTC_EDGES);
  localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);
  localparam logic [RW-1:0] RTC_LAST = RW'(RTC_EDGES - 1);
  logic [PW-1:0] pre_reg, pre_next;
  logic [RW-1:0] rtc_cnt_reg, rtc_cnt_next;
  logic rtc_prev_reg, comp_prev_reg;
  logic div_tick_next, rtc_tick_next, comp_tick_next;
  logic rtc_rise;

  always_comb begin
    rtc_rise = rtc_in & ~rtc_prev_reg;
    div_tick_next = (pre_reg == PRE_LAST);
    pre_next = div_tick_next ? '0 : PW'(pre_reg + 1'b1);
    rtc_cnt_next = rtc_cnt_reg;
    rtc_tick_next = 1'b0;
    if (rtc_rise) begin
      rtc_tick_next = (rtc_cnt_reg == RTC_LAST);
      rtc_cnt_next = rtc_tick_next ? '0 : RW'(rtc_cnt_reg + 1'b1);
    end
    comp_tick_next = comparator_in & ~comp_prev_reg;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pre_reg <= '0;
      rtc_cnt_reg <= '0;
      rtc_prev_reg <= 1'b0;
      comp_prev_reg <= 1'b0;
      div12_tick <= 1'b0;
      rtc8_tick <= 1'b0;
      comp_tick <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      rtc_cnt_reg <= rtc_cnt_next;
      rtc_prev_reg <= rtc_in;
      comp_prev_reg <= comparator_in;
      div12_tick <= div_tick_next;
      rtc8_tick <= rtc_tick_next;
      comp_tick <= comp_tick_next;
    end
  end

  a_div_period: assert property (@(posedge clock) disable iff (rst) // RULE13
    div12_tick |=> !div12_tick [*8])
    else $error("prescale tick came too soon");
endmodule : tcf_tick_gen

// *** tcf_byte_counter.sv ***
// Purpose: one 8-bit counter byte with wrap load and software write
// Assumes: software write wins over counting in the same cycle
// Notes: at_max is combinational from the count
`timescale 1ns/1ns
module tcf_byte_counter (
  input wire logic clock,
  input wire logic rst,
  input wire logic inc,
  input wire logic wrap_load,
  input wire logic [7:0] reload_value,
  input wire logic sw_write,
  input wire logic [7:0] sw_data,
  output logic [7:0] count,
  output logic at_max
);
  logic [7:0] count_next;

  always_comb begin
    at_max = (count == tcf_pkg::BYTE_MAX);
    count_next = count;
    if (sw_write) begin
      count_next = sw_data;
    end else if (inc) begin
      if (at_max) begin
        count_next = wrap_load ? reload_value : tcf_pkg::BYTE_ZERO;
      end else begin
        count_next = 8'(count + 8'h01);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count <= tcf_pkg::BYTE_RESET;
    end else begin
      count <= count_next;
    end
  end
endmodule : tcf_byte_counter

// *** tcf_timer.sv ***
// Purpose: control/status register and counting core of an auto-reload timer
// Assumes: register port strobes one cycle, read data valid the next cycle
// Notes: bit writes reach the control register through the bit port
//
// What this block does
// RULE1: the high flag sets when the upper byte rolls from all ones to zero.
// RULE2: in 16-bit mode the high flag sets when the whole counter wraps to zero.
// RULE3: with the timer interrupt enabled, a set high flag requests an interrupt.
// RULE4: the low flag sets on every lower byte rollover in either mode.
// RULE5: hardware never clears the flags; software clears them by writing.
// RULE6: with low-byte enable and timer interrupt on, each low rollover interrupts.
// RULE7: a one in capture enable selects capture mode, a zero normal counting.
// RULE8: split bit one gives two 8-bit reload counters, zero one 16-bit counter.
// RULE9: the control register sits at 0xC8 on page 0 and is bit addressable.
// RULE10: a full 16-bit wrap loads the reload value together with the high flag; with capture enable set the code wraps to zero instead.
// RULE11: a capture copies the counter into the reload registers and sets the high flag.
// RULE12: run control gates counting; in split mode only the upper byte.
// RULE13: the 2-bit select picks the external clock and the capture trigger.
// RULE14: a hardware set beats a software clear in the same cycle.
`timescale 1ns/1ns
module tcf_timer (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [3:0] page,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic bit_wr,
  input wire logic [7:0] bit_addr,
  input wire logic bit_value,
  input wire logic high_use_system_clock,
  input wire logic low_use_system_clock,
  input wire logic rtc_in,
  input wire logic comparator_in,
  output logic irq
);
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] rl_low_reg, rl_low_next, rl_high_reg, rl_high_next;
  logic [7:0] rdata_next;
  logic [tcf_pkg::IRQ_WIDTH-1:0] ist_reg, ist_next, ien_reg, ien_next;
  logic [tcf_pkg::IRQ_WIDTH-1:0] ist_set, ist_clr;
  logic div12_tick, rtc8_tick, comp_tick;
  logic ext_tick, trig_tick, low_tick, high_tick;
  logic low_inc, high_inc, low_wrap, high_wrap, cap_evt;
  logic low_max, high_max, low_wrap_load;
  logic hi_set, lo_set, ctrl_bit_hit, ctrl_wr;
  logic [7:0] count_low, count_high;
  logic split, run, cen;
  logic [1:0] xclk;

  function automatic logic tcf_hit(input logic [7:0] a, input logic [3:0] p,
                                   input logic [7:0] target);
    return (p == tcf_pkg::SFR_PAGE) && (a == target);
  endfunction : tcf_hit

  assign split = ctrl_reg[tcf_pkg::BIT_SPLIT];
  assign run = ctrl_reg[tcf_pkg::BIT_RUN];
  assign cen = ctrl_reg[tcf_pkg::BIT_CAPTURE_EN];
  assign xclk = ctrl_reg[tcf_pkg::BIT_XCLK_HI:tcf_pkg::BIT_XCLK_LO];

  tcf_tick_gen u_ticks (
    .clock(clock),
    .rst(rst),
    .rtc_in(rtc_in),
    .comparator_in(comparator_in),
    .div12_tick(div12_tick),
    .rtc8_tick(rtc8_tick),
    .comp_tick(comp_tick)
  );

  // RULE13 source select
  always_comb begin
    unique case (xclk)
      tcf_pkg::XCLK_DIV12_RTC: begin
        ext_tick = div12_tick;
        trig_tick = rtc8_tick;
      end
      tcf_pkg::XCLK_COMP_RTC: begin
        ext_tick = comp_tick;
        trig_tick = rtc8_tick;
      end
      tcf_pkg::XCLK_DIV12_COMP: begin
        ext_tick = div12_tick;
        trig_tick = comp_tick;
      end
      tcf_pkg::XCLK_RTC_COMP: begin
        ext_tick = rtc8_tick;
        trig_tick = comp_tick;
      end
    endcase
  end

  // RULE8 mode structure, RULE12 run gating
  always_comb begin
    low_tick = low_use_system_clock | ext_tick;
    high_tick = high_use_system_clock | ext_tick;
    if (split) begin
      low_inc = low_tick;
      high_inc = run & high_tick;
    end else begin
      low_inc = run & low_tick;
      high_inc = low_inc & low_max;
    end
    low_wrap = low_inc & low_max;
    high_wrap = high_inc & high_max;
    // RULE7 capture trigger
    cap_evt = cen & trig_tick;
    // RULE10 full wrap reloads; capture mode wraps to zero to keep timing free-running
    low_wrap_load = ~cen & (split | high_max);
  end

  tcf_byte_counter u_low (
    .clock(clock),
    .rst(rst),
    .inc(low_inc),
    .wrap_load(low_wrap_load),
    .reload_value(rl_low_reg),
    .sw_write(wr && tcf_hit(addr, page, tcf_pkg::ADDR_COUNT_LOW)),
    .sw_data(wdata),
    .count(count_low),
    .at_max(low_max)
  );

  tcf_byte_counter u_high (
    .clock(clock),
    .rst(rst),
    .inc(high_inc),
    .wrap_load(~cen),
    .reload_value(rl_high_reg),
    .sw_write(wr && tcf_hit(addr, page, tcf_pkg::ADDR_COUNT_HIGH)),
    .sw_data(wdata),
    .count(count_high),
    .at_max(high_max)
  );

  // control register with byte and bit writes
  always_comb begin
    // RULE1 upper byte rollover, RULE2 16-bit wrap, RULE11 capture
    // flag follows the increment request even when a counter write wins
    hi_set = high_wrap | cap_evt;
    // RULE4 low rollover in both modes
    lo_set = low_wrap;
    ctrl_wr = wr && tcf_hit(addr, page, tcf_pkg::ADDR_CONTROL);
    // RULE9 bit addresses 0xC8..0xCF
    ctrl_bit_hit = bit_wr && (page == tcf_pkg::SFR_PAGE) &&
                   (bit_addr[7:3] == tcf_pkg::CONTROL_BIT_BASE);
    ctrl_next = ctrl_reg;
    if (ctrl_wr) begin
      ctrl_next = wdata;
    end else if (ctrl_bit_hit) begin
      ctrl_next[bit_addr[2:0]] = bit_value;
    end
    // RULE5 flags only set here; RULE14 set beats clear
    if (hi_set) begin
      ctrl_next[tcf_pkg::BIT_HIGH_FLAG] = 1'b1;
    end
    if (lo_set) begin
      ctrl_next[tcf_pkg::BIT_LOW_FLAG] = 1'b1;
    end
  end

  // reload registers; capture beats a software write
  always_comb begin
    rl_low_next = rl_low_reg;
    rl_high_next = rl_high_reg;
    if (wr && tcf_hit(addr, page, tcf_pkg::ADDR_RELOAD_LOW)) begin
      rl_low_next = wdata;
    end
    if (wr && tcf_hit(addr, page, tcf_pkg::ADDR_RELOAD_HIGH)) begin
      rl_high_next = wdata;
    end
    // RULE11 capture copy
    if (cap_evt) begin
      rl_low_next = count_low;
      rl_high_next = count_high;
    end
  end

  // interrupt status, enable and clear
  always_comb begin
    ist_set = '0;
    // RULE3 high flag event
    ist_set[tcf_pkg::IRQ_HIGH] = hi_set;
    // RULE6 low event only with low-byte enable
    ist_set[tcf_pkg::IRQ_LOW] = lo_set & ctrl_reg[tcf_pkg::BIT_LOW_IRQ_EN];
    ist_clr = '0;
    if (wr && tcf_hit(addr, page, tcf_pkg::ADDR_IRQ_CLEAR)) begin
      ist_clr = wdata[tcf_pkg::IRQ_WIDTH-1:0];
    end
    // RULE14 set wins over clear
    ist_next = ist_set | (ist_reg & ~ist_clr);
    ien_next = ien_reg;
    if (wr && tcf_hit(addr, page, tcf_pkg::ADDR_IRQ_ENABLE)) begin
      ien_next = wdata[tcf_pkg::IRQ_WIDTH-1:0];
    end
    irq = |(ist_reg & ien_reg);
  end

  // read mux; unmapped reads give zero
  always_comb begin
    rdata_next = 8'h00;
    if (rd && page == tcf_pkg::SFR_PAGE) begin
      unique case (addr)
        tcf_pkg::ADDR_CONTROL: rdata_next = ctrl_reg;
        tcf_pkg::ADDR_RELOAD_LOW: rdata_next = rl_low_reg;
        tcf_pkg::ADDR_RELOAD_HIGH: rdata_next = rl_high_reg;
        tcf_pkg::ADDR_COUNT_LOW: rdata_next = count_low;
        tcf_pkg::ADDR_COUNT_HIGH: rdata_next = count_high;
        tcf_pkg::ADDR_IRQ_STATUS: rdata_next = {6'h00, ist_reg};
        tcf_pkg::ADDR_IRQ_ENABLE: rdata_next = {6'h00, ien_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= tcf_pkg::CONTROL_RESET;
      rl_low_reg <= tcf_pkg::BYTE_RESET;
      rl_high_reg <= tcf_pkg::BYTE_RESET;
      ist_reg <= tcf_pkg::IRQ_RESET;
      ien_reg <= tcf_pkg::IRQ_RESET;
      rdata <= 8'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      rl_low_reg <= rl_low_next;
      rl_high_reg <= rl_high_next;
      ist_reg <= ist_next;
      ien_reg <= ien_next;
      rdata <= rdata_next;
    end
  end

  a_high_wrap_flag: assert property (@(posedge clock) disable iff (rst) // RULE1
    high_inc && count_high == 8'hFF |=> ctrl_reg[7])
    else $error("high rollover did not set high flag");

  a_full_wrap_flag: assert property (@(posedge clock) disable iff (rst) // RULE2
    !split && low_inc && count_low == 8'hFF && count_high == 8'hFF |=> ctrl_reg[7])
    else $error("16-bit wrap did not set high flag");

  a_high_irq_raise: assert property (@(posedge clock) disable iff (rst) // RULE3
    hi_set && ien_reg[0] |=> irq)
    else $error("high event with enable gave no interrupt");

  a_low_wrap_flag: assert property (@(posedge clock) disable iff (rst) // RULE4
    low_inc && count_low == 8'hFF |=> ctrl_reg[6])
    else $error("low rollover did not set low flag");

  a_flag_sticky: assert property (@(posedge clock) disable iff (rst) // RULE5
    ctrl_reg[7] && !ctrl_wr && !ctrl_bit_hit |=> ctrl_reg[7])
    else $error("high flag cleared without software");

  a_low_irq_gate: assert property (@(posedge clock) disable iff (rst) // RULE6
    low_wrap && ctrl_reg[5] && ien_reg[1] |=> irq && ist_reg[1])
    else $error("low event with enables gave no interrupt");

  a_capture_gate: assert property (@(posedge clock) disable iff (rst) // RULE7
    !cen && !wr
    |=> rl_low_reg == $past(rl_low_reg) && rl_high_reg == $past(rl_high_reg))
    else $error("reload changed outside capture mode");

  a_split_low_free: assert property (@(posedge clock) disable iff (rst) // RULE8
    split && !run && low_tick && count_low != 8'hFF && !wr
    |=> count_low == 8'($past(count_low) + 8'h01))
    else $error("split low byte did not count");

  a_control_read: assert property (@(posedge clock) disable iff (rst) // RULE9
    rd && page == 4'h0 && addr == 8'hC8 |=> rdata == $past(ctrl_reg))
    else $error("control read at 0xC8 wrong");

  a_reload_load: assert property (@(posedge clock) disable iff (rst) // RULE10
    !split && !cen && high_wrap && !wr
    |=> count_low == $past(rl_low_reg) && count_high == $past(rl_high_reg))
    else $error("16-bit wrap did not load reload value");

  a_capture_copy: assert property (@(posedge clock) disable iff (rst) // RULE11
    cap_evt |=> rl_low_reg == $past(count_low) && rl_high_reg == $past(count_high)
    && ctrl_reg[7])
    else $error("capture copy or flag missing");

  a_run_hold_high: assert property (@(posedge clock) disable iff (rst) // RULE12
    split && !run && !wr |=> count_high == $past(count_high))
    else $error("stopped high byte moved");

  a_set_over_clear: assert property (@(posedge clock) disable iff (rst) // RULE14
    lo_set && ctrl_wr && !wdata[6] |=> ctrl_reg[6])
    else $error("low flag set lost to clear");

  a_low_zero_wrap: assert property (@(posedge clock) disable iff (rst) // RULE8
    !split && low_wrap && !high_max && !wr |=> count_low == 8'h00)
    else $error("partial 16-bit wrap did not go to zero");

  a_select_comp: assert property (@(posedge clock) disable iff (rst) // RULE13
    !split && run && !low_use_system_clock && xclk == tcf_pkg::XCLK_COMP_RTC |-> low_inc == comp_tick)
    else $error("comparator select did not clock low byte");

  a_select_rtc: assert property (@(posedge clock) disable iff (rst) // RULE13
    !split && run && !low_use_system_clock && xclk == tcf_pkg::XCLK_RTC_COMP |-> low_inc == rtc8_tick)
    else $error("rtc select did not clock low byte");

  a_bit_write: assert property (@(posedge clock) disable iff (rst) // RULE9
    ctrl_bit_hit && !ctrl_wr && bit_addr[2:0] == 3'h2 |=> run == $past(bit_value))
    else $error("bit write to run control lost");
endmodule : tcf_timer

// *** tcf_cpu_model.sv ***
// Purpose: processor-side interrupt watcher for the timer block
// Assumes: irq is a level sampled on the rising clock edge
// Notes: counts entries into the timer service routine
`timescale 1ns/1ns
module tcf_cpu_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic irq,
  output int vector_count
);
  logic irq_seen_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_seen_reg <= 1'b0;
      vector_count <= 0;
    end else begin
      irq_seen_reg <= irq;
      // a level held high enters the routine once, not every cycle
      if (irq && !irq_seen_reg) begin
        vector_count <= vector_count + 1;
      end
    end
  end
endmodule : tcf_cpu_model

// *** tcf_timer_tb_top.sv ***
// Purpose: self-checking bench for the timer control and status register
// Assumes: no long counts; external ticks come from short input pulses
// Notes: register port and bit port driven by tasks
`timescale 1ns/1ns
module tcf_timer_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [3:0] page = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic bit_wr = 1'b0;
  logic [7:0] bit_addr = 8'h00;
  logic bit_value = 1'b0;
  logic high_use_system_clock = 1'b1;
  logic low_use_system_clock = 1'b1;
  logic rtc_in = 1'b0;
  logic comparator_in = 1'b0;
  logic irq;
  int vector_count;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;

  always #20 clock = ~clock;

  tcf_timer u_tcf_timer (.clock(clock), .rst(rst), .addr(addr), .page(page),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bit_wr(bit_wr),
    .bit_addr(bit_addr), .bit_value(bit_value), .high_use_system_clock(high_use_system_clock),
    .low_use_system_clock(low_use_system_clock), .rtc_in(rtc_in), .comparator_in(comparator_in),
    .irq(irq));
  tcf_cpu_model u_tcf_cpu_model (.clock(clock), .rst(rst), .irq(irq),
    .vector_count(vector_count));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask : chk1

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk8(name, exp, rdata);
  endtask : reg_rd

  task automatic bit_set(input logic [2:0] idx, input logic v);
    @(posedge clock);
    bit_addr <= {tcf_pkg::CONTROL_BIT_BASE, idx};
    bit_value <= v;
    bit_wr <= 1'b1;
    @(posedge clock);
    bit_wr <= 1'b0;
  endtask : bit_set

  task automatic pulse(input logic comp, input int n);
    repeat (n) begin
      @(posedge clock);
      if (comp) comparator_in <= 1'b1;
      else rtc_in <= 1'b1;
      @(posedge clock);
      comparator_in <= 1'b0;
      rtc_in <= 1'b0;
    end
  endtask : pulse

  task automatic irq_chk(input logic exp);
    @(posedge clock);
    #1;
    chk1("irq", exp, irq);
  endtask : irq_chk

  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    reg_rd(8'hC8, 8'h00, "control reset");
    @(posedge clock);
    page <= 4'h1;
    reg_wr(8'hC8, 8'h04);
    page <= 4'h0;
    reg_rd(8'hC8, 8'h00, "control other page");
    reg_rd(8'hC9, 8'h00, "unmapped");
    reg_rd(8'hD2, 8'h00, "clear reg");
    // 16-bit wrap loads the reload value
    reg_wr(8'hCA, 8'h34);
    reg_wr(8'hCB, 8'h12);
    reg_wr(8'hCC, 8'hFE);
    reg_wr(8'hCD, 8'hFF);
    bit_set(3'h2, 1'b1);
    repeat (4) @(posedge clock);
    bit_set(3'h2, 1'b0);
    reg_rd(8'hCD, 8'h12, "count high");
    reg_rd(8'hC8, 8'hC0, "flags 16-bit");
    repeat (50) @(posedge clock);
    reg_rd(8'hC8, 8'hC0, "flags held");
    reg_rd(8'hD0, 8'h01, "status");
    irq_chk(1'b0);
    reg_wr(8'hD1, 8'h01);
    irq_chk(1'b1);
    chk8("vectors", 8'h01, 8'(vector_count));
    reg_wr(8'hD2, 8'h01);
    irq_chk(1'b0);
    reg_wr(8'hC8, 8'h00);
    reg_rd(8'hC8, 8'h00, "flags cleared");
    // split: low runs alone, high waits for run
    reg_wr(8'hCA, 8'h50);
    reg_wr(8'hCC, 8'hFD);
    reg_wr(8'hCD, 8'hFF);
    reg_wr(8'hCB, 8'h77);
    reg_wr(8'hC8, 8'h28);
    repeat (8) @(posedge clock);
    reg_rd(8'hCD, 8'hFF, "high stopped");
    reg_rd(8'hC8, 8'h68, "low flag split");
    reg_rd(8'hD0, 8'h02, "low status");
    reg_wr(8'hD1, 8'h03);
    irq_chk(1'b1);
    bit_set(3'h2, 1'b1);
    repeat (4) @(posedge clock);
    bit_set(3'h2, 1'b0);
    reg_rd(8'hC8, 8'hE8, "high flag split");
    reg_wr(8'hD2, 8'h03);
    reg_wr(8'hC8, 8'h00);
    // capture on every eighth rtc edge
    reg_wr(8'hCC, 8'h78);
    reg_wr(8'hCD, 8'h56);
    reg_wr(8'hC8, 8'h10);
    pulse(1'b0, 7);
    repeat (3) @(posedge clock);
    reg_rd(8'hC8, 8'h10, "no capture yet");
    pulse(1'b0, 1);
    repeat (3) @(posedge clock);
    reg_rd(8'hCB, 8'h56, "capture high");
    reg_rd(8'hCA, 8'h78, "capture low");
    reg_rd(8'hC8, 8'h90, "capture flag");
    // select 10 moves the trigger to the comparator
    reg_wr(8'hC8, 8'h12);
    reg_wr(8'hCC, 8'hBC);
    reg_wr(8'hCD, 8'h9A);
    pulse(1'b0, 8);
    repeat (3) @(posedge clock);
    reg_rd(8'hCB, 8'h56, "rtc ignored");
    pulse(1'b1, 1);
    repeat (3) @(posedge clock);
    reg_rd(8'hCB, 8'h9A, "comp capture");
    reg_rd(8'hC8, 8'h92, "comp flag");
    reg_wr(8'hC8, 8'h02);
    reg_wr(8'hCD, 8'h11);
    pulse(1'b1, 1);
    repeat (3) @(posedge clock);
    reg_rd(8'hCB, 8'h9A, "normal mode");
    reg_rd(8'hC8, 8'h02, "no flag");
    // external ticks: comparator, then rtc/8, clock the 16-bit counter
    @(posedge clock);
    low_use_system_clock <= 1'b0;
    reg_wr(8'hCC, 8'hFE);
    reg_wr(8'hC8, 8'h05);
    pulse(1'b1, 3);
    reg_rd(8'hCC, 8'h01, "comp clocked low");
    reg_rd(8'hCD, 8'h12, "carry into high");
    reg_rd(8'hC8, 8'h45, "low flag 16-bit");
    reg_wr(8'hC8, 8'h07);
    pulse(1'b0, 8);
    reg_rd(8'hCC, 8'h02, "rtc clocked low");
    test_done();
  end
endmodule : tcf_timer_tb_top
